// file: rtl/scfg_pkg.sv
// Purpose: Constants, state type and checksum helper for the serial
//          configuration port and EEPROM read-back controller.
// Assumes: core_clk at 25 MHz.
// Notes:   Cycle counts derive from the times below.
package scfg_pkg;

	localparam int CLK_MHZ = 25;
	// Read-back clock half period and select-high gap
	localparam int HALF_NS  = 5000;
	localparam int GAP_NS   = 10000;
	localparam int HALF_CYC = HALF_NS * CLK_MHZ / 1000;
	localparam int GAP_CYC  = GAP_NS * CLK_MHZ / 1000;
	localparam logic [8:0] HALF_LAST = 9'(HALF_CYC - 1);
	localparam logic [8:0] GAP_LAST  = 9'(GAP_CYC - 1);

	// Host command byte layout
	localparam int DIR_BIT = 7;
	localparam logic [7:0] PASS_CMD = 8'h7f;

	// EEPROM read sequence
	localparam logic [7:0] EE_READ_OP = 8'h03;
	localparam logic [7:0] EE_FIRST   = 8'h04;
	localparam int CMD_BITS   = 16;
	localparam int DATA_BYTES = 12;
	localparam logic [6:0] CMD_END = 7'(CMD_BITS);
	localparam logic [6:0] RB_LAST = 7'(CMD_BITS + 8 * DATA_BYTES - 1);

	// Register set
	localparam logic [3:0] CFG_FIRST = 4'h4;
	localparam logic [3:0] CSUM_IDX  = 4'hf;
	localparam int RBD_BIT = 0;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] CSUM_OK = 8'hff;

	typedef enum logic [1:0] {RB_IDLE, RB_GAP, RB_SHIFT} scfg_rb_t;

	// End-around-carry add used by both checksum paths
	function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction

endpackage

// file: rtl/scfg_loader.sv
// Purpose: Serial config port, EEPROM pass-through and read-back loader.
// Assumes: sclkIn is the shared serial clock pin seen as a clock.
// Notes:   The data pin is split into per-source driver pairs; the clock pin has one read-back pair.
`timescale 1ns/1ps
module scfg_loader
	import scfg_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        coreEn,
	input  wire logic        sclkIn,
	input  wire logic        hostSelect_n,
	input  wire logic        dataIn,
	output logic             sclkOut,
	output logic             sclkOe_n,
	output logic             rbDataOut,
	output logic             rbDataOe_n,
	output logic             linkDataOut,
	output logic             linkDataOe_n,
	output logic             eepromSelect_n,
	output logic             checksumErrorFlag,
	output logic             forceUnderScale,
	output logic             readbackDisable,
	output logic [95:0]      cfgImage
);

	////////////////////////////////////////////////////////////////////
	// Link side, clocked by the host's serial clock

	logic       lFirst_r;
	logic       lRead_r;
	logic       lPass_r;
	logic [2:0] lBit_r;
	logic [3:0] lIdx_r;
	logic [7:0] lShift_r;
	logic [7:0] lTx_r;
	logic       wrTog_r;
	logic [7:0] wrByteL_r;
	logic [3:0] wrIdxL_r;
	logic [15:0][7:0] regs_r;

	// Link logic rests in reset whenever the host is not selected, so
	// read-back clock edges seen on the pin do nothing here
	wire       linkRst_n = arst_n & ~hostSelect_n;
	wire [7:0] lByte     = {lShift_r[6:0], dataIn};
	wire       lByteEnd  = (lBit_r == 3'h7) && !lPass_r;
	wire       lWrite    = lByteEnd && !lFirst_r && !lRead_r;
	wire       lLoad     = (lBit_r == 3'h0) && !lFirst_r && lRead_r && !lPass_r;

	always_ff @(posedge sclkIn or negedge linkRst_n) begin
		if (!linkRst_n) begin
			lFirst_r <= 1'b1;
			lRead_r  <= 1'b0;
			lPass_r  <= 1'b0;
			lBit_r   <= 3'h0;
			lIdx_r   <= 4'h0;
			lShift_r <= 8'h00;
		end else if (!lPass_r) begin
			lShift_r <= lByte;
			lBit_r   <= lBit_r + 3'h1;
			if (lByteEnd && lFirst_r) begin
				lFirst_r <= 1'b0;
				lRead_r  <= lByte[DIR_BIT];
				lIdx_r   <= lByte[3:0];
				lPass_r  <= (lByte == PASS_CMD);
			end else if (lByteEnd) begin
				lIdx_r <= lIdx_r + 4'h1;
			end
		end
	end

	// Kept out of the frame reset so a toggle never jumps back
	always_ff @(posedge sclkIn or negedge arst_n) begin
		if (!arst_n) begin
			wrTog_r   <= 1'b0;
			wrByteL_r <= 8'h00;
			wrIdxL_r  <= 4'h0;
		end else if (lWrite && linkRst_n) begin
			wrTog_r   <= ~wrTog_r;
			wrByteL_r <= lByte;
			wrIdxL_r  <= lIdx_r;
		end
	end

	// Register words are static while the host owns the bus: read-back
	// is aborted and a write lands microseconds before the next load
	always_ff @(negedge sclkIn or negedge linkRst_n) begin
		if (!linkRst_n) begin
			lTx_r        <= 8'h00;
			linkDataOut  <= 1'b0;
			linkDataOe_n <= 1'b1;
		end else if (lLoad) begin
			lTx_r        <= regs_r[lIdx_r];
			linkDataOut  <= regs_r[lIdx_r][7];
			linkDataOe_n <= 1'b0;
		end else begin
			lTx_r       <= {lTx_r[6:0], 1'b0};
			linkDataOut <= lTx_r[6];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Synchronisers into core_clk

	logic       hsMeta_r;
	logic       hsSync_r;
	logic       hsSyncD_r;
	logic       psMeta_r;
	logic       psSync_r;
	logic       dMeta_r;
	logic       dSync_r;
	logic [2:0] wtSync_r;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hsMeta_r  <= 1'b1;
			hsSync_r  <= 1'b1;
			hsSyncD_r <= 1'b1;
			psMeta_r  <= 1'b0;
			psSync_r  <= 1'b0;
			dMeta_r   <= 1'b0;
			dSync_r   <= 1'b0;
			wtSync_r  <= 3'h0;
		end else if (coreEn) begin
			hsMeta_r  <= hostSelect_n;
			hsSync_r  <= hsMeta_r;
			hsSyncD_r <= hsSync_r;
			psMeta_r  <= lPass_r;
			psSync_r  <= psMeta_r;
			dMeta_r   <= dataIn;
			dSync_r   <= dMeta_r;
			wtSync_r  <= {wtSync_r[1:0], wrTog_r};
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read-back sequencer decode

	scfg_rb_t   rbState_r;
	logic [8:0] cnt_r;
	logic [6:0] bitIdx_r;
	logic [7:0] rxByte_r;
	logic [7:0] sum_r;
	logic [7:0] hSum_r;
	logic       csErr_r;
	logic       rbdEff_r;

	wire        hostAct  = !hsSync_r;
	wire        hostFall = hsSyncD_r && !hsSync_r;
	wire        rbShift  = (rbState_r == RB_SHIFT);
	wire        halfEnd  = (cnt_r == HALF_LAST);
	wire        gapEnd   = (cnt_r == GAP_LAST);
	wire        riseEv   = rbShift && halfEnd && !sclkOut;
	wire        fallEv   = rbShift && halfEnd && sclkOut;
	wire        inData   = (bitIdx_r >= CMD_END);
	wire [7:0]  rxNxt    = {rxByte_r[6:0], dSync_r};
	wire        byteEv   = riseEv && inData && (bitIdx_r[2:0] == 3'h7);
	wire [6:0]  rel      = bitIdx_r - CMD_END;
	wire [3:0]  rbIdx    = CFG_FIRST + rel[6:3];
	wire [7:0]  rbSumNxt = csum_add(sum_r, rxNxt);
	wire        lastEv   = fallEv && (bitIdx_r == RB_LAST);
	wire [6:0]  bitNxt   = bitIdx_r + 7'h01;
	wire [15:0] cmdWord  = {EE_READ_OP, EE_FIRST};
	wire        cmdBit   = cmdWord[4'hf - bitNxt[3:0]];
	wire        sumOk    = (sum_r == CSUM_OK);
	wire        stopNxt  = sumOk ? regs_r[CFG_FIRST][RBD_BIT] : rbdEff_r;
	wire        wrEv     = wtSync_r[2] ^ wtSync_r[1];
	wire        wrCfg    = wrEv && (wrIdxL_r >= CFG_FIRST);
	wire        wrCsum   = wrEv && (wrIdxL_r == CSUM_IDX);
	wire [7:0]  hSumNxt  = csum_add(hSum_r, wrByteL_r);
	wire        hostOk   = (hSumNxt == CSUM_OK);

	////////////////////////////////////////////////////////////////////
	// Read-back sequencer

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rbState_r <= RB_IDLE;
			cnt_r     <= 9'h000;
			bitIdx_r  <= 7'h00;
		end else if (coreEn) begin
			cnt_r <= cnt_r + 9'h001;
			case (rbState_r)
				RB_IDLE: begin
					cnt_r <= 9'h000;
					if (!hostAct && !rbdEff_r) begin
						rbState_r <= RB_GAP;
					end
				end
				RB_GAP: begin
					if (gapEnd) begin
						rbState_r <= RB_SHIFT;
						cnt_r     <= 9'h000;
						bitIdx_r  <= 7'h00;
					end
				end
				RB_SHIFT: begin
					if (halfEnd) begin
						cnt_r <= 9'h000;
					end
					if (fallEv) begin
						bitIdx_r <= bitNxt;
					end
					if (lastEv) begin
						rbState_r <= stopNxt ? RB_IDLE : RB_GAP;
					end
				end
				default: rbState_r <= RB_IDLE;
			endcase
			if (hostAct) begin
				rbState_r <= RB_IDLE;
			end
		end
	end

	// Pin drivers of the read-back side
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclkOut        <= 1'b0;
			sclkOe_n       <= 1'b1;
			rbDataOut      <= 1'b0;
			rbDataOe_n     <= 1'b1;
			eepromSelect_n <= 1'b1;
			rxByte_r       <= 8'h00;
		end else if (coreEn) begin
			if (hostAct) begin
				sclkOe_n       <= 1'b1;
				rbDataOe_n     <= 1'b1;
				eepromSelect_n <= !psSync_r;
			end else if (rbState_r == RB_IDLE) begin
				sclkOe_n       <= 1'b1;
				rbDataOe_n     <= 1'b1;
				eepromSelect_n <= 1'b1;
				sclkOut        <= 1'b0;
			end else if (rbState_r == RB_GAP) begin
				sclkOe_n       <= 1'b0;
				sclkOut        <= 1'b0;
				eepromSelect_n <= !gapEnd;
				rbDataOe_n     <= !gapEnd;
				rbDataOut      <= cmdWord[15];
			end else if (riseEv) begin
				sclkOut  <= 1'b1;
				rxByte_r <= inData ? rxNxt : rxByte_r;
			end else if (fallEv) begin
				sclkOut        <= 1'b0;
				rbDataOut      <= cmdBit;
				rbDataOe_n     <= (bitNxt >= CMD_END);
				eepromSelect_n <= lastEv;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register set, checksum and read-back disable

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			regs_r <= {16{REG_RST}};
		end else if (coreEn) begin
			if (byteEv) begin
				regs_r[rbIdx] <= rxNxt;
			end else if (wrEv) begin
				regs_r[wrIdxL_r] <= wrByteL_r;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sum_r    <= 8'h00;
			hSum_r   <= 8'h00;
			csErr_r  <= 1'b0;
			rbdEff_r <= 1'b0;
		end else if (coreEn) begin
			if (rbState_r == RB_GAP) begin
				sum_r <= 8'h00;
			end else if (byteEv) begin
				sum_r <= rbSumNxt;
			end
			if (hostFall) begin
				hSum_r <= 8'h00;
			end else if (wrCfg) begin
				hSum_r <= hSumNxt;
			end
			if (lastEv) begin
				csErr_r  <= !sumOk;
				rbdEff_r <= stopNxt;
			end else if (wrCsum) begin
				csErr_r  <= !hostOk;
				rbdEff_r <= hostOk ? regs_r[CFG_FIRST][RBD_BIT] : rbdEff_r;
			end
		end
	end

	// The analogue side needs a registered copy for its error level
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			checksumErrorFlag <= 1'b0;
			forceUnderScale   <= 1'b0;
			readbackDisable   <= 1'b0;
		end else if (coreEn) begin
			checksumErrorFlag <= csErr_r;
			forceUnderScale   <= csErr_r;
			readbackDisable   <= rbdEff_r;
		end
	end

	assign cfgImage = regs_r[15:4];

	////////////////////////////////////////////////////////////////////
	// Checks

	sequence sPassEnd;
		lastEv && coreEn;
	endsequence

	sequence sGapDone;
		rbState_r == RB_GAP && gapEnd && coreEn && !hostAct;
	endsequence

	a_host_abort: assert property (@(posedge core_clk) disable iff (!arst_n)
		hostAct && coreEn |=> sclkOe_n && rbDataOe_n && rbState_r == RB_IDLE)
		else $error("read-back not released on host select");

	a_sel_regacc: assert property (@(posedge core_clk) disable iff (!arst_n)
		hostAct && !psSync_r && coreEn |=> eepromSelect_n)
		else $error("EEPROM select active in register access");

	a_sel_pass: assert property (@(posedge core_clk) disable iff (!arst_n)
		hostAct && psSync_r && coreEn |=> !eepromSelect_n)
		else $error("EEPROM select missing in pass-through");

	a_sel_release: assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(hsSync_r) && coreEn |=> eepromSelect_n)
		else $error("EEPROM select held after host release");

	a_gap_start: assert property (@(posedge core_clk) disable iff (!arst_n)
		sGapDone |=> rbShift && !eepromSelect_n && cnt_r == 9'h000)
		else $error("read-back did not start after the gap");

	a_half_width: assert property (@(posedge core_clk) disable iff (!arst_n)
		rbShift && coreEn && !hostAct && $changed(sclkOut) |-> $past(cnt_r) == HALF_LAST)
		else $error("read-back clock half period wrong");

	a_loop_again: assert property (@(posedge core_clk) disable iff (!arst_n)
		sPassEnd and !stopNxt && !hostAct |=> rbState_r == RB_GAP && eepromSelect_n)
		else $error("read-back did not restart");

	a_stop_once: assert property (@(posedge core_clk) disable iff (!arst_n)
		rbState_r == RB_IDLE && rbdEff_r |=> rbState_r == RB_IDLE)
		else $error("read-back restarted while disabled");

	a_csum_write: assert property (@(posedge core_clk) disable iff (!arst_n)
		wrCsum && coreEn && !lastEv |=> csErr_r == ($past(hSumNxt) != CSUM_OK))
		else $error("checksum flag wrong after checksum write");

	a_partial_wr: assert property (@(posedge core_clk) disable iff (!arst_n)
		wrEv && !wrCsum && !lastEv |=> $stable(csErr_r))
		else $error("checksum flag changed by partial write");

	a_under_scale: assert property (@(posedge core_clk) disable iff (!arst_n)
		coreEn && csErr_r |=> forceUnderScale)
		else $error("error level not forced");

	a_ee_no_write: assert property (@(posedge core_clk) disable iff (!arst_n)
		rbShift && inData |-> rbDataOe_n)
		else $error("data driven during EEPROM data phase");

	a_write_input: assert property (@(posedge sclkIn) disable iff (!linkRst_n)
		!lRead_r || lFirst_r |-> linkDataOe_n)
		else $error("data line driven during a write");

endmodule

// file: bench/scfg_eeprom_model.sv
// Purpose: Serial EEPROM stand-in on the read-back port.
// Assumes: Command is opcode then address, data follows MSB first.
// Notes:   Writes are ignored, since the loader never writes.
`timescale 1ns/1ps
module scfg_eeprom_model (
	input  wire logic sclk,
	input  wire logic si,
	input  wire logic sel_n,
	output logic      so,
	output logic      soEn
);
	logic [7:0]  mem [0:15];
	logic [15:0] cmdR;
	logic        drv = 1'b0;
	int          cnt;

	always @(posedge sclk or posedge sel_n) begin
		if (sel_n) begin
			cnt <= 0;
		end else begin
			if (cnt < 16) begin
				cmdR <= {cmdR[14:0], si};
			end
			cnt <= cnt + 1;
		end
	end

	// Output released as soon as select rises, no hold
	always @(negedge sclk or posedge sel_n) begin
		if (sel_n) begin
			drv <= 1'b0;
		end else if (cnt >= 16 && cnt < 112) begin
			drv <= 1'b1;
			so  <= mem[4'(cmdR[3:0] + 4'((cnt - 16) / 8))][7 - (cnt - 16) % 8];
		end
	end

	// Gated by select too, since select and the last fall share a time step
	assign soEn = drv && !sel_n;
endmodule

// file: bench/scfg_loader_tb.sv
// Purpose: Self-checking bench for the serial config loader.
// Assumes: Host link clock 80 ns, only within frames.
// Notes:   A released data pin toggles each cycle so stale bits never pass.
`timescale 1ns/1ps
module scfg_loader_tb;
	import scfg_pkg::*;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        hostSelect_n = 1'b1;
	logic        hostSclk = 1'b0;
	logic        hostData = 1'b0;
	logic        hostDrive = 1'b0;
	logic        coreEn = 1'b1;
	logic        floatBit = 1'b0;
	logic        sclkOut, sclkOe_n, rbDataOut, rbDataOe_n, linkDataOut, linkDataOe_n;
	logic        eepromSelect_n, checksumErrorFlag, forceUnderScale, readbackDisable;
	logic        eeSo, eeSoEn, sclkPin, dataPin;
	logic [95:0] cfgImage;
	logic [7:0]  img [4:15];
	logic [7:0]  rx;
	int          fails = 0;
	int          checked = 0;
	int          cycles = 0;
	int          gap;

	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) floatBit <= ~floatBit;
	// Host owns the clock from just before its select until release
	assign sclkPin = (hostDrive || !hostSelect_n || sclkOe_n) ? hostSclk : sclkOut;
	assign dataPin = !rbDataOe_n ? rbDataOut : !linkDataOe_n ? linkDataOut :
		(eeSoEn && !eepromSelect_n) ? eeSo : hostDrive ? hostData : floatBit;

	scfg_loader dut_u (.core_clk(core_clk), .arst_n(arst_n), .coreEn(coreEn),
		.sclkIn(sclkPin), .hostSelect_n(hostSelect_n), .dataIn(dataPin),
		.sclkOut(sclkOut), .sclkOe_n(sclkOe_n), .rbDataOut(rbDataOut),
		.rbDataOe_n(rbDataOe_n), .linkDataOut(linkDataOut), .linkDataOe_n(linkDataOe_n),
		.eepromSelect_n(eepromSelect_n), .checksumErrorFlag(checksumErrorFlag),
		.forceUnderScale(forceUnderScale), .readbackDisable(readbackDisable),
		.cfgImage(cfgImage));
	scfg_eeprom_model ee_u (.sclk(sclkPin), .si(dataPin), .sel_n(eepromSelect_n),
		.so(eeSo), .soEn(eeSoEn));

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [95:0] got, input logic [95:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Whole run needs about 70k cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic waitSel(input logic lvl, input int lim, output int n);
		n = 0;
		while (eepromSelect_n !== lvl && n < lim) begin
			@(negedge core_clk);
			n++;
		end
		check(eepromSelect_n, lvl);
	endtask

	function automatic logic [95:0] pack();
		logic [95:0] v;
		for (int i = 4; i < 16; i++) v[8*(i-4) +: 8] = img[i];
		return v;
	endfunction

	function automatic void fixSum();
		int s;
		s = 0;
		for (int i = 4; i < 15; i++) begin
			s = s + img[i];
			if (s > 255) s = s - 255;
		end
		img[15] = 8'(255 - s);
	endfunction

	////////////////////////////////////////////////////////////////
	task automatic hostBegin();
		@(posedge core_clk);
		hostDrive <= 1'b1;
		@(posedge core_clk);
		hostSelect_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		check({eepromSelect_n, rbDataOe_n, sclkOe_n}, 3'b111);
		repeat (1000) @(posedge core_clk);
		#13;
	endtask

	task automatic xfer(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			hostData <= b[i];
			#40 hostSclk <= 1'b1;
			rx[i] = dataPin;
			#40 hostSclk <= 1'b0;
		end
	endtask

	task automatic hostEnd();
		#40 hostSelect_n <= 1'b1;
		hostDrive <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask

	task automatic writeRegs(input logic [3:0] first, input int n);
		hostBegin();
		xfer({4'h0, first});
		for (int i = 0; i < n; i++) xfer(img[first + i]);
		check({linkDataOe_n, eepromSelect_n}, 2'b11);
		hostEnd();
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_readback();
		logic [2:0] held;
		for (int i = 4; i < 15; i++) img[i] = 8'h10 + 8'(i);
		fixSum();
		for (int i = 4; i < 16; i++) ee_u.mem[i] = img[i];
		waitSel(1'b0, 400, gap);
		waitSel(1'b1, 28500, gap);
		waitSel(1'b0, 400, gap);
		check(gap >= 245 && gap <= 255, 1'b1);
		check(cfgImage, pack());
		check({checksumErrorFlag, readbackDisable}, 2'b00);
		repeat (4200) @(posedge core_clk);
		check(ee_u.cmdR, {EE_READ_OP, EE_FIRST});
		// One half period frozen: a live sequencer would toggle the clock once
		coreEn <= 1'b0;
		@(posedge core_clk);
		held = {sclkOut, eepromSelect_n, sclkOe_n};
		repeat (125) @(posedge core_clk);
		check({sclkOut, eepromSelect_n, sclkOe_n}, held);
		coreEn <= 1'b1;
	endtask

	task automatic t_partial();
		img[5] = 8'haa;
		img[6] = 8'h56;
		writeRegs(4'h5, 2);
		check(cfgImage[23:8], 16'h56aa);
		check(checksumErrorFlag, 1'b0);
		img[5] = 8'h15;
		img[6] = 8'h16;
		waitSel(1'b0, 400, gap);
		waitSel(1'b1, 28500, gap);
		check(cfgImage, pack());
	endtask

	task automatic t_badsum();
		img[4] = 8'h01;
		fixSum();
		img[15] = ~img[15];
		writeRegs(4'h4, 12);
		check({checksumErrorFlag, forceUnderScale, readbackDisable}, 3'b110);
		img[6] = 8'hff;
		writeRegs(4'h6, 1);
		check(checksumErrorFlag, 1'b1);
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		check({checksumErrorFlag, readbackDisable}, 2'b00);
	endtask

	task automatic t_disable();
		fixSum();
		writeRegs(4'h4, 12);
		check({checksumErrorFlag, forceUnderScale, readbackDisable}, 3'b001);
		check(cfgImage, pack());
		repeat (600) @(posedge core_clk);
		check({eepromSelect_n, sclkOe_n}, 2'b11);
	endtask

	task automatic t_read();
		logic [7:0] b0;
		hostBegin();
		xfer(8'h84);
		hostDrive <= 1'b0;
		xfer(8'h00);
		b0 = rx;
		xfer(8'h00);
		check({b0, rx, eepromSelect_n}, {img[4], img[5], 1'b1});
		hostEnd();
		check(linkDataOe_n, 1'b1);
	endtask

	task automatic t_pass();
		hostBegin();
		xfer(PASS_CMD);
		repeat (4) @(posedge core_clk);
		check(eepromSelect_n, 1'b0);
		#13;
		xfer(8'h04);
		xfer(8'hff);
		hostEnd();
		check({eepromSelect_n, cfgImage}, {1'b1, pack()});
	endtask

	initial begin
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		check({checksumErrorFlag, eepromSelect_n}, 2'b01);
		t_readback();
		t_partial();
		t_badsum();
		t_disable();
		t_read();
		t_pass();
		tally_and_finish();
	end
endmodule
